// [verilog/ddr2_mode_regs.vh]
/*
 Command decode values, mode register field positions, strobe/termination
 encodings and timing counts for the mode register and termination block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DDR2_MODE_REGS_VH
`define DDR2_MODE_REGS_VH

// Mode register select on bank address (BA1,BA0)
`define SEL_MR 2'h0
`define SEL_EMR1 2'h1
`define SEL_EMR2 2'h2
`define SEL_EMR3 2'h3

// Base mode register fields
`define MR_BL_LSB 0
`define MR_BT_BIT 3
`define MR_CL_LSB 4
`define MR_TM_BIT 7
`define MR_DLLRST_BIT 8
`define MR_WR_LSB 9

// Extended register one fields
`define EMR1_DLLDIS_BIT 0
`define EMR1_DRV_BIT 1
`define EMR1_RTT0_BIT 2
`define EMR1_RTT1_BIT 6
`define EMR1_OCD_LSB 7
`define EMR1_NDQS_DIS_BIT 10
`define EMR1_RDQS_EN_BIT 11
`define EMR1_QOFF_BIT 12

// Extended register two fields
`define EMR2_DCC_BIT 3

// Burst length codes
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3

// Termination nominal codes {A6,A2}
`define RTT_OFF 2'h0
`define RTT_SW_A 2'h1
`define RTT_SW_B 2'h2
`define RTT_SW_C 2'h3

// Register reset value (register three holds zero until written)
`define MODE_RESET 14'h0000

// DLL lock time in clock cycles, and termination update window
`define DLL_LOCK_CYCLES 200
`define TMOD_MIN_CYCLES 0
`define TMOD_MAX_CYCLES 12

`endif

// [verilog/ddr2_mode_register_and_odt.v]
/*
 Mode register, extended mode registers and on-die termination control
 of a DDR2 memory device, sampled on the rising edge of the memory clock.
 Assumes command pins are synchronous to CLK_I (same clock domain as the
 controller) and that the controller honours precharge, tMRD and CKE
 ordering on its own side.
 Limitation: register three is stored but drives no output.
*/
// Summary of operation
// - All low including BA selects base register
// - BA0 high with BA1 low selects extended register one
// - BA1 high with BA0 low selects extended register two
// - Register writes never touch array contents
// - Burst length, type, CAS latency fields
// - Test mode, DLL reset, write recovery
// - DLL, driver, termination, strobe option bits
// - Read strobe replaces mask when enabled
// - Calibration field left zero
// - Self-refresh stops DLL, exit resets it
// - Output disable stops read drivers
// - Duty correction bit, refresh fields zero
// - Termination pin switches nominal resistance
// - No termination during self-refresh
// - New termination applied within update window
// - A0 low enables DLL
`timescale 1ns/10ps
`include "ddr2_mode_regs.vh"

module ddr2_mode_register_and_odt
#(
   parameter AW = 14,
   parameter DLL_LOCK = `DLL_LOCK_CYCLES,
   parameter TMOD_MAX = `TMOD_MAX_CYCLES
)
(
   // Clock and reset
   input wire CLK_I,
   input wire RESET_N_I,
   // Command and address pins
   input wire CKE_I,
   input wire CS_N_I,
   input wire RAS_N_I,
   input wire CAS_N_I,
   input wire WE_N_I,
   input wire [1:0] BA_I,
   input wire [AW-1:0] ADDR_I,
   input wire ODT_I,
   // State from the rest of the device
   input wire SELF_REFRESH_I,
   input wire READ_ACTIVE_I,
   // Base register fields
   output reg [2:0] BURST_LEN_O,
   output reg BURST_TYPE_O,
   output reg [2:0] CAS_LAT_O,
   output reg TEST_MODE_O,
   output reg [2:0] WRITE_REC_O,
   // Extended register fields
   output reg DRIVE_REDUCED_O,
   output reg INV_STROBE_DIS_O,
   output reg READ_STROBE_EN_O,
   output reg OUTPUT_DIS_O,
   output reg DUTY_CYCLE_CORRECTION_O,
   // DLL control
   output reg DLL_ENABLE_O,
   output reg DLL_RESET_O,
   output reg DLL_LOCKED_O,
   // Strobe and data pin roles
   output wire DM_IS_STROBE_O,
   output wire RDQS_N_OE_O,
   output wire DQS_N_OE_O,
   output wire DQ_OE_O,
   // Termination switches
   output reg TERMINATION_SWITCH_A_O,
   output reg TERMINATION_SWITCH_B_O,
   output reg TERMINATION_SWITCH_C_O
);

   // ************************************************************
   // Pin synchronisation
   // ************************************************************
   reg odt_meta_r;
   reg odt_sync_r;
   reg sr_meta_r;
   reg sr_sync_r;
   reg sr_prev_r;

   // ODT and self-refresh come from outside logic, two stages each
   // Only the second stage feeds logic; the first may still be settling
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         odt_meta_r <= 1'b0;
         odt_sync_r <= 1'b0;
         sr_meta_r <= 1'b0;
         sr_sync_r <= 1'b0;
         sr_prev_r <= 1'b0;
      end
      else
      begin
         odt_meta_r <= ODT_I;
         odt_sync_r <= odt_meta_r;
         sr_meta_r <= SELF_REFRESH_I;
         sr_sync_r <= sr_meta_r;
         sr_prev_r <= sr_sync_r;
      end
   end

   // ************************************************************
   // Command decode
   // ************************************************************
   wire mrs_cmd;
   wire wr_mr;
   wire wr_emr1;
   wire wr_emr2;
   wire wr_emr3;
   wire sr_exit;

   // CKE low turns any register set into a no-op
   // low command pins mean register set
   assign mrs_cmd = CKE_I & ~CS_N_I & ~RAS_N_I & ~CAS_N_I & ~WE_N_I;
   assign wr_mr = mrs_cmd & (BA_I == `SEL_MR);
   assign wr_emr1 = mrs_cmd & (BA_I == `SEL_EMR1);
   assign wr_emr2 = mrs_cmd & (BA_I == `SEL_EMR2);
   // register three holds only reserved bits
   assign wr_emr3 = mrs_cmd & (BA_I == `SEL_EMR3);
   // Falling edge of the synced level; both flops reset low, so no false exit
   assign sr_exit = sr_prev_r & ~sr_sync_r;

   // ************************************************************
   // Register storage
   // ************************************************************
   // Register three is kept for completeness; no field of it is decoded
   reg [AW-1:0] emr3_r;
   reg [1:0] rtt_cur_r;
   reg [1:0] rtt_new_r;
   reg [7:0] tmod_cnt_r;
   reg [7:0] lock_cnt_r;
   reg dll_rst_req;

   // rising edge capture, held until rewritten
   // every field replaced on each write
   // only these flops change; no array access here
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         BURST_LEN_O <= `BL_CODE_4;
         BURST_TYPE_O <= 1'b0;
         CAS_LAT_O <= 3'h0;
         TEST_MODE_O <= 1'b0;
         WRITE_REC_O <= 3'h0;
         DRIVE_REDUCED_O <= 1'b0;
         INV_STROBE_DIS_O <= 1'b0;
         READ_STROBE_EN_O <= 1'b0;
         OUTPUT_DIS_O <= 1'b0;
         DUTY_CYCLE_CORRECTION_O <= 1'b0;
         DLL_ENABLE_O <= 1'b0;
         rtt_new_r <= `RTT_OFF;
         emr3_r <= `MODE_RESET;
      end
      else
      begin
         if (wr_mr)
         begin
            BURST_LEN_O <= ADDR_I[`MR_BL_LSB+2:`MR_BL_LSB];
            BURST_TYPE_O <= ADDR_I[`MR_BT_BIT];
            CAS_LAT_O <= ADDR_I[`MR_CL_LSB+2:`MR_CL_LSB];
            TEST_MODE_O <= ADDR_I[`MR_TM_BIT];
            WRITE_REC_O <= ADDR_I[`MR_WR_LSB+2:`MR_WR_LSB];
         end
         if (wr_emr1)
         begin
            DRIVE_REDUCED_O <= ADDR_I[`EMR1_DRV_BIT];
            INV_STROBE_DIS_O <= ADDR_I[`EMR1_NDQS_DIS_BIT];
            READ_STROBE_EN_O <= ADDR_I[`EMR1_RDQS_EN_BIT];
            OUTPUT_DIS_O <= ADDR_I[`EMR1_QOFF_BIT];
            // new value parked until the window ends
            rtt_new_r <= {ADDR_I[`EMR1_RTT1_BIT], ADDR_I[`EMR1_RTT0_BIT]};
            // calibration bits ignored, no calibration engine
         end
         if (wr_emr2)
            DUTY_CYCLE_CORRECTION_O <= ADDR_I[`EMR2_DCC_BIT];
         if (wr_emr3)
            emr3_r <= ADDR_I;
         // Self-refresh wins over a register write in the same cycle
         // self-refresh entry stops the DLL
         if (sr_sync_r)
            DLL_ENABLE_O <= 1'b0;
         else if (sr_exit)
            DLL_ENABLE_O <= 1'b1;
         else if (wr_emr1)
            DLL_ENABLE_O <= ~ADDR_I[`EMR1_DLLDIS_BIT];
      end
   end

   // ************************************************************
   // DLL reset and lock tracking
   // ************************************************************
   // A8 requests reset; self-refresh exit resets too
   always @*
   begin
      dll_rst_req = (wr_mr & ADDR_I[`MR_DLLRST_BIT]) | sr_exit;
   end

   // Every reset pulse restarts the count, so a late reset re-arms the wait
   // A base register write with A8 low leaves the lock state alone
   // locked flag after 200 cycles, for read gating
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         DLL_RESET_O <= 1'b0;
         DLL_LOCKED_O <= 1'b0;
         lock_cnt_r <= 8'h00;
      end
      else
      begin
         DLL_RESET_O <= dll_rst_req;
         if (dll_rst_req || !DLL_ENABLE_O)
         begin
            DLL_LOCKED_O <= 1'b0;
            lock_cnt_r <= 8'h00;
         end
         else if (!DLL_LOCKED_O)
         begin
            if (lock_cnt_r == DLL_LOCK[7:0] - 8'h01)
               DLL_LOCKED_O <= 1'b1;
            lock_cnt_r <= lock_cnt_r + 8'h01;
         end
      end
   end

   // ************************************************************
   // Termination update window and switches
   // ************************************************************
   // Applying at the maximum lands late, never early, while ODT is held low
   // new value applied at end of update window
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         rtt_cur_r <= `RTT_OFF;
         tmod_cnt_r <= 8'h00;
      end
      else if (wr_emr1)
         tmod_cnt_r <= TMOD_MAX[7:0];
      else if (tmod_cnt_r != 8'h00)
      begin
         tmod_cnt_r <= tmod_cnt_r - 8'h01;
         if (tmod_cnt_r == 8'h01)
            rtt_cur_r <= rtt_new_r;
      end
   end

   // Switches lag the pins by three edges, the price of synchronising them
   // pin switches nominal resistance; off in self-refresh
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         TERMINATION_SWITCH_A_O <= 1'b0;
         TERMINATION_SWITCH_B_O <= 1'b0;
         TERMINATION_SWITCH_C_O <= 1'b0;
      end
      else
      begin
         TERMINATION_SWITCH_A_O <= odt_sync_r & ~sr_sync_r & (rtt_cur_r == `RTT_SW_A);
         TERMINATION_SWITCH_B_O <= odt_sync_r & ~sr_sync_r & (rtt_cur_r == `RTT_SW_B);
         TERMINATION_SWITCH_C_O <= odt_sync_r & ~sr_sync_r & (rtt_cur_r == `RTT_SW_C);
      end
   end

   // ************************************************************
   // Strobe and output pin roles
   // ************************************************************
   // Enables stay combinational so they follow READ_ACTIVE_I without delay
   // mask pin becomes read strobe when enabled
   assign DM_IS_STROBE_O = READ_STROBE_EN_O;
   // complement driven only with inverted strobes on
   assign RDQS_N_OE_O = READ_ACTIVE_I & ~OUTPUT_DIS_O & READ_STROBE_EN_O & ~INV_STROBE_DIS_O;
   // strobe complement follows the A10 disable and output disable, not the read strobe enable
   assign DQS_N_OE_O = READ_ACTIVE_I & ~OUTPUT_DIS_O & ~INV_STROBE_DIS_O;
   assign DQ_OE_O = READ_ACTIVE_I & ~OUTPUT_DIS_O;

endmodule

// [testbench/mode_regs_checker.sv]
/* Assertions on the ports of the mode register and termination block.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/10ps
module mode_regs_checker #(parameter AW = 14)
(
   // Clock, reset and command pins
   input wire CLK_I, RESET_N_I, CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I,
   input wire [1:0] BA_I,
   input wire [AW-1:0] ADDR_I,
   input wire SELF_REFRESH_I,
   // Watched outputs
   input wire [2:0] BURST_LEN_O, CAS_LAT_O,
   input wire DLL_RESET_O, DLL_ENABLE_O, READ_STROBE_EN_O, INV_STROBE_DIS_O,
   input wire OUTPUT_DIS_O, DUTY_CYCLE_CORRECTION_O, RDQS_N_OE_O, DQ_OE_O,
   input wire TERMINATION_SWITCH_A_O
);
   // Register write as seen at the pins
   wire wr = CKE_I & ~CS_N_I & ~RAS_N_I & ~CAS_N_I & ~WE_N_I;
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   a_burst_len: assert property (wr && BA_I == 2'h0 |=>
      BURST_LEN_O == $past(ADDR_I[2:0])) else $error("burst length not taken");
   a_cas_lat: assert property (wr && BA_I == 2'h0 |=>
      CAS_LAT_O == $past(ADDR_I[6:4])) else $error("CAS latency not taken");
   a_dll_reset: assert property (wr && BA_I == 2'h0 && ADDR_I[8] |=>
      DLL_RESET_O) else $error("no DLL reset pulse");
   a_dll_enable: assert property (wr && BA_I == 2'h1 |=>
      DLL_ENABLE_O == !$past(ADDR_I[0])) else $error("DLL enable wrong");
   a_strobe_en: assert property (wr && BA_I == 2'h1 |=>
      READ_STROBE_EN_O == $past(ADDR_I[11])) else $error("read strobe enable wrong");
   a_duty_corr: assert property (wr && BA_I == 2'h2 |=>
      DUTY_CYCLE_CORRECTION_O == $past(ADDR_I[3])) else $error("duty correction wrong");
   a_cke_hold: assert property (!CKE_I |=>
      $stable(BURST_LEN_O) && $stable(CAS_LAT_O)) else $error("write taken with CKE low");
   a_sr_term: assert property (SELF_REFRESH_I [*4] |->
      !TERMINATION_SWITCH_A_O && !DLL_ENABLE_O) else $error("active in self-refresh");
   a_inv_strobe: assert property (RDQS_N_OE_O |->
      READ_STROBE_EN_O && !INV_STROBE_DIS_O) else $error("strobe complement driven");
   a_out_dis: assert property (DQ_OE_O |-> !OUTPUT_DIS_O)
      else $error("data driven while disabled");
   c_emr1: cover property (wr && BA_I == 2'h1);
   c_dll_reset: cover property (DLL_RESET_O);
   c_term_on: cover property (TERMINATION_SWITCH_A_O);
endmodule

bind ddr2_mode_register_and_odt mode_regs_checker #(.AW(AW)) u_mode_regs_checker
(
   .CLK_I, .RESET_N_I, .CKE_I, .CS_N_I, .RAS_N_I, .CAS_N_I, .WE_N_I, .BA_I, .ADDR_I,
   .SELF_REFRESH_I, .BURST_LEN_O, .CAS_LAT_O, .DLL_RESET_O, .DLL_ENABLE_O,
   .READ_STROBE_EN_O, .INV_STROBE_DIS_O, .OUTPUT_DIS_O, .DUTY_CYCLE_CORRECTION_O,
   .RDQS_N_OE_O, .DQ_OE_O, .TERMINATION_SWITCH_A_O
);

// [testbench/ctl_model.sv]
/* Memory controller model: drives command, address and termination pins.
   Assumes the bench calls its tasks from a single process. */
`timescale 1ns/10ps
module ctl_model
(
   input wire clk_i,
   output logic cke_o = 1'b1,
   output logic cs_n_o = 1'b1, ras_n_o = 1'b1, cas_n_o = 1'b1, we_n_o = 1'b1,
   output logic [1:0] ba_o = 2'h0,
   output logic [13:0] addr_o = 14'h0000,
   output logic odt_o = 1'b0
);
   // one write, then a full deselect cycle with CKE high
   task automatic cmd(input logic ke, input logic [1:0] b, input logic [13:0] a);
      @(posedge clk_i);
      cke_o <= ke;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h0;
      ba_o <= b;
      addr_o <= a;
      @(posedge clk_i);
      cke_o <= 1'b1;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
      // Idle lines show the inverse, so stale bits never look valid
      ba_o <= ~b;
      addr_o <= ~a;
   endtask
   // Termination pin level, changed just after an edge
   task automatic odt(input logic v);
      @(posedge clk_i);
      odt_o <= v;
   endtask
endmodule

// [testbench/test_ddr2_mode_register_and_odt.sv]
/* Bench for the mode register block: the controller model issues writes,
   integer fields here predict the field and pin role outputs; lock and switches use constants. Assumes one 40 MHz clock. */
`timescale 1ns/10ps
module test_ddr2_mode_register_and_odt;
   // Short lock and update counts keep the run brief
   localparam LOCK = 20;
   localparam TM = 4;
   // write recovery of 30 ns rounded up to 25 ns clocks
   localparam TWR_NS = 30;
   localparam WR_CYC = (TWR_NS + 24) / 25;
   logic CLK_I = 0;
   logic RESET_N_I = 0;
   logic SELF_REFRESH_I = 0;
   logic READ_ACTIVE_I = 0;
   logic [31:0] seed = 19;
   logic [31:0] r;
   wire CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, ODT_I;
   wire [1:0] BA_I;
   wire [13:0] ADDR_I;
   wire [2:0] BURST_LEN_O, CAS_LAT_O, WRITE_REC_O;
   wire BURST_TYPE_O, TEST_MODE_O, DRIVE_REDUCED_O, INV_STROBE_DIS_O, READ_STROBE_EN_O;
   wire OUTPUT_DIS_O, DUTY_CYCLE_CORRECTION_O, DLL_ENABLE_O, DLL_RESET_O, DLL_LOCKED_O;
   wire DM_IS_STROBE_O, RDQS_N_OE_O, DQS_N_OE_O, DQ_OE_O;
   wire TERMINATION_SWITCH_A_O, TERMINATION_SWITCH_B_O, TERMINATION_SWITCH_C_O;
   int bad_count = 0;
   int comparisons = 0;
   int bl = 2, bt, cl, tm, wrc, drv, ndis, rdqs, qoff, dll, dcc;

   always #12.5 CLK_I = ~CLK_I;

   ddr2_mode_register_and_odt #(.AW(14), .DLL_LOCK(LOCK), .TMOD_MAX(TM))
      u_ddr2_mode_register_and_odt
   (
      .CLK_I, .RESET_N_I, .CKE_I, .CS_N_I, .RAS_N_I, .CAS_N_I, .WE_N_I, .BA_I, .ADDR_I,
      .ODT_I, .SELF_REFRESH_I, .READ_ACTIVE_I, .BURST_LEN_O, .BURST_TYPE_O, .CAS_LAT_O,
      .TEST_MODE_O, .WRITE_REC_O, .DRIVE_REDUCED_O, .INV_STROBE_DIS_O, .READ_STROBE_EN_O,
      .OUTPUT_DIS_O, .DUTY_CYCLE_CORRECTION_O, .DLL_ENABLE_O, .DLL_RESET_O, .DLL_LOCKED_O,
      .DM_IS_STROBE_O, .RDQS_N_OE_O, .DQS_N_OE_O, .DQ_OE_O, .TERMINATION_SWITCH_A_O,
      .TERMINATION_SWITCH_B_O, .TERMINATION_SWITCH_C_O
   );

   ctl_model u_ctl_model
   (
      .clk_i(CLK_I), .cke_o(CKE_I), .cs_n_o(CS_N_I), .ras_n_o(RAS_N_I), .cas_n_o(CAS_N_I),
      .we_n_o(WE_N_I), .ba_o(BA_I), .addr_o(ADDR_I), .odt_o(ODT_I)
   );

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Settle past the edge before looking
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_I);
      #1;
   endtask

   // One write, model update, then every field compared
   task automatic wr(input logic ke, input logic [1:0] b, input logic [13:0] a);
      u_ctl_model.cmd(ke, b, a);
      #1;
      // One integer per field, each taken from its own address bits
      if (ke && b == 2'h0)
      begin
         wrc = a[11:9];
         cl = a[6:4];
         bt = a[3];
         bl = a[2:0];
         tm = a[7];
      end
      if (ke && b == 2'h1)
      begin
         qoff = a[12];
         rdqs = a[11];
         ndis = a[10];
         drv = a[1];
         dll = !a[0];
      end
      if (ke && b == 2'h2)
         dcc = a[3];
      check(BURST_LEN_O, bl);
      check(BURST_TYPE_O, bt);
      check(CAS_LAT_O, cl);
      check(TEST_MODE_O, tm);
      check(WRITE_REC_O, wrc);
      check(DLL_RESET_O, ke && b == 2'h0 && a[8]);
      check(DLL_ENABLE_O, dll);
      check(DRIVE_REDUCED_O, drv);
      check(INV_STROBE_DIS_O, ndis);
      check(READ_STROBE_EN_O, rdqs);
      check(OUTPUT_DIS_O, qoff);
      check(DUTY_CYCLE_CORRECTION_O, dcc);
      check(DQ_OE_O, READ_ACTIVE_I && !qoff);
      check(RDQS_N_OE_O, READ_ACTIVE_I && rdqs && !ndis && !qoff);
      check(DQS_N_OE_O, READ_ACTIVE_I && !ndis && !qoff);
      check(DM_IS_STROBE_O, rdqs);
   endtask

   // Main sequence
   initial
   begin
      repeat (4) @(posedge CLK_I);
      RESET_N_I <= 1'b1;
      tick(1);
      check(BURST_LEN_O, 3'h2);
      for (int i = 0; i < 40; i++)
      begin
         r = xs();
         @(posedge CLK_I);
         READ_ACTIVE_I <= r[20];
         // reserved fields zero, every 5th with CKE low
         case (i % 4)
            0: wr(i % 5 != 4, 2'h0, {2'h0, r[11:9], r[8], 1'b0, r[6:3], 2'b01, r[0]});
            1: wr(i % 5 != 4, 2'h1, {1'b0, r[12:10], 3'h0, r[6:0]});
            2: wr(i % 5 != 4, 2'h2, {10'h000, r[3], 3'h0});
            default: wr(i % 5 != 4, 2'h3, 14'h0000);
         endcase
      end
      wr(1'b1, 2'h1, 14'h0000);
      wr(1'b1, 2'h0, 14'h0132 | 14'(WR_CYC << 9));
      tick(LOCK - 1);
      check(DLL_LOCKED_O, 1'b0);
      tick(1);
      check(DLL_LOCKED_O, 1'b1);
      for (int c = 0; c < 4; c++)
      begin
         u_ctl_model.odt(1'b0);
         wr(1'b1, 2'h1, {7'h00, c[1], 3'h0, c[0], 2'h0});
         tick(TM + 2);
         check({TERMINATION_SWITCH_C_O, TERMINATION_SWITCH_B_O, TERMINATION_SWITCH_A_O},
            0);
         u_ctl_model.odt(1'b1);
         tick(6);
         check({TERMINATION_SWITCH_C_O, TERMINATION_SWITCH_B_O, TERMINATION_SWITCH_A_O},
            (c == 0) ? 0 : 1 << (c - 1));
      end
      @(posedge CLK_I);
      SELF_REFRESH_I <= 1'b1;
      tick(6);
      check({TERMINATION_SWITCH_C_O, TERMINATION_SWITCH_B_O, TERMINATION_SWITCH_A_O}, 0);
      check(DLL_ENABLE_O, 1'b0);
      @(posedge CLK_I);
      SELF_REFRESH_I <= 1'b0;
      tick(6);
      check(DLL_ENABLE_O, 1'b1);
      check(TERMINATION_SWITCH_C_O, 1'b1);
      print_verdict();
   end

   // Watchdog well beyond the few hundred cycles the sequence needs
   initial
   begin
      repeat (5000) @(posedge CLK_I);
      bad_count++;
      print_verdict();
   end
endmodule
